// ==== stmh_defs.svh ====
`ifndef STMH_DEFS_SVH
`define STMH_DEFS_SVH

// homing option bit positions and reset value
`define STMH_HO_REV 0
`define STMH_HO_REF1 4
`define STMH_HO_REF2 5
`define STMH_HO_RST 8'h30

// referencing velocities: 500 toward the cam, 50 away from it
`define STMH_VAP_RST 16'h01f4
`define STMH_VRE_RST 16'h0032
`define STMH_RPOS_RST 16'h0000

// per-target defaults: position 0, velocity and acceleration 2047
`define STMH_TPOS_RST 32'h0000_0000
`define STMH_TGT_RST 16'h07ff

// feature config word bit positions and reset value
`define STMH_FC_CTAB 7
`define STMH_FC_SHOW 10
`define STMH_FC_GLO 12
`define STMH_FC_GHI 13
`define STMH_FC_FILT 14
`define STMH_FC_CNT 15
`define STMH_FC_RST 16'h4000

// microstep size codes: 0 is 1/64 up to 6 which is full step
`define STMH_MSS_64 3'h0
`define STMH_MSS_MAX 3'h6

// drive status and control word bit positions
`define STMH_SW_DONE 0
`define STMH_SW_BUSY 1
`define STMH_SW_C 6
`define STMH_SW_G 7
`define STMH_CW_LATCH 6

// encoder input filter settle time
`define STMH_CLK_MHZ 100
`define STMH_FILT_NS 50
`define STMH_FILT_CYC ((`STMH_FILT_NS * `STMH_CLK_MHZ + 999) / 1000)

`endif

// ==== stmh_pkg.sv ====
package stmh_pkg;

    typedef enum logic [1:0] {
        HS_IDLE,
        HS_SEEK,
        HS_LEAVE
    } stmh_home_st_t;

    typedef enum logic [2:0] {
        TS_TPOS_LO,
        TS_TPOS_HI,
        TS_TVEL,
        TS_TACC,
        TS_CTAB
    } stmh_tbl_sel_t;

    typedef struct packed {
        logic [7:0] opts;
        logic [15:0] v_app;
        logic [15:0] v_ret;
        logic [15:0] rpos_lo;
        logic [15:0] rpos_hi;
    } stmh_home_cfg_t;

    typedef struct packed {
        logic a;
        logic b;
        logic c;
        logic gate;
    } stmh_enc_t;

    typedef struct packed {
        logic run;
        logic dir;
        logic [15:0] vel;
    } stmh_home_drv_t;

    typedef struct packed {
        logic go;
        logic [31:0] tgt;
        logic [15:0] vel;
        logic [15:0] acc;
    } stmh_move_t;

endpackage

// ==== stmh_glitch_filt.sv ====
`timescale 1ns/1ps
// passes a level only after it has held steady for CYC cycles
module stmh_glitch_filt #(
    parameter int CYC = 5
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic din,
    input wire logic bypass,
    output logic dout
);
    typedef struct packed {
        logic [7:0] cnt;
        logic val;
    } stmh_filt_st_t;

    stmh_filt_st_t r;
    stmh_filt_st_t next_r;

    // restart the count on every change, accept when it runs out
    always_comb begin
        next_r = r;
        if (din == r.val) begin
            next_r.cnt = 8'h00;
        end else if (r.cnt >= 8'(CYC - 1)) begin
            next_r.val = din;
            next_r.cnt = 8'h00;
        end else begin
            next_r.cnt = r.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // bypass trades glitch immunity for lower latency
    assign dout = bypass ? din : r.val;
endmodule

// ==== stmh_quarter_map.sv ====
`timescale 1ns/1ps
// maps an electrical phase to a coil current magnitude and sign
module stmh_quarter_map (
    input wire logic [7:0] phase,
    input wire logic [63:0][3:0] user_tab,
    input wire logic use_user,
    output logic [3:0] mag,
    output logic neg
);
    logic [5:0] idx;

    // coarse internal sine, one entry per four fine steps
    function automatic logic [3:0] sine_q(input logic [3:0] k);
        logic [63:0] lut;
        lut = 64'hffed_dccb_a876_4310;
        return lut[k*4 +: 4];
    endfunction

    // odd quarters run backward, the second half flips sign
    always_comb begin
        idx = phase[6] ? ~phase[5:0] : phase[5:0];
        neg = phase[7];
        mag = use_user ? user_tab[idx] : sine_q(idx[5:2]);
    end
endmodule

// ==== stmh_top.sv ====
`timescale 1ns/1ps
`include "stmh_defs.svh"
module stmh_top #(
    parameter int NTGT = 16,
    parameter int VW = 16
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic path_mode,
    input wire logic cfg_we,
    input wire stmh_pkg::stmh_home_cfg_t home_cfg,
    input wire logic [15:0] feature_config_word,
    input wire logic [2:0] microstep_size_select,
    input wire logic tbl_we,
    input wire logic tbl_re,
    input wire stmh_pkg::stmh_tbl_sel_t tbl_sel,
    input wire logic [3:0] tbl_idx,
    input wire logic [15:0] tbl_wdata,
    output logic [15:0] tbl_rdata,
    input wire logic home_start,
    input wire logic ref_in1,
    input wire logic ref_in2,
    output stmh_pkg::stmh_home_drv_t home_drv,
    output logic pos_load,
    output logic [31:0] pos_load_val,
    input wire logic move_start,
    input wire logic [3:0] move_idx,
    output stmh_pkg::stmh_move_t move,
    input wire stmh_pkg::stmh_enc_t enc_in,
    input wire logic [15:0] drive_control_word,
    output logic [7:0] drive_status_word,
    output logic [31:0] enc_count,
    input wire logic step_pulse,
    input wire logic step_dir,
    output logic [4:0] coil_a,
    output logic [4:0] coil_b
);
    typedef struct packed {
        stmh_pkg::stmh_home_st_t hs;
        stmh_pkg::stmh_home_cfg_t hc;
        logic [15:0] fcw;
        logic [2:0] mss;
        logic [NTGT-1:0][31:0] tpos;
        logic [NTGT-1:0][VW-1:0] tvel;
        logic [NTGT-1:0][VW-1:0] tacc;
        logic [15:0][15:0] ctab;
        logic a_q;
        logic [31:0] cnt;
        logic [7:0] phase;
        logic done;
        logic [15:0] rdata;
        stmh_pkg::stmh_home_drv_t hd;
        logic pload;
        logic [31:0] pval;
        stmh_pkg::stmh_move_t mv;
        logic [7:0] sw;
        logic [4:0] ca;
        logic [4:0] cb;
    } stmh_st_t;

    stmh_st_t r;
    stmh_st_t next_r;
    stmh_st_t rst_val;

    stmh_pkg::stmh_enc_t ef;
    logic cam;
    logic blocked;
    logic a_rise;
    logic cnt_en;
    logic use_user;
    logic [7:0] step_inc;
    logic [3:0] mag_a;
    logic [3:0] mag_b;
    logic neg_a;
    logic neg_b;

    // filter each encoder line; clearing the filter bit bypasses it
    stmh_glitch_filt #(.CYC(`STMH_FILT_CYC)) u_fa (
        .clk_sys(clk_sys), .rst_n(rst_n), .din(enc_in.a),
        .bypass(!r.fcw[`STMH_FC_FILT]), .dout(ef.a));
    stmh_glitch_filt #(.CYC(`STMH_FILT_CYC)) u_fb (
        .clk_sys(clk_sys), .rst_n(rst_n), .din(enc_in.b),
        .bypass(!r.fcw[`STMH_FC_FILT]), .dout(ef.b));
    stmh_glitch_filt #(.CYC(`STMH_FILT_CYC)) u_fc (
        .clk_sys(clk_sys), .rst_n(rst_n), .din(enc_in.c),
        .bypass(!r.fcw[`STMH_FC_FILT]), .dout(ef.c));
    stmh_glitch_filt #(.CYC(`STMH_FILT_CYC)) u_fg (
        .clk_sys(clk_sys), .rst_n(rst_n), .din(enc_in.gate),
        .bypass(!r.fcw[`STMH_FC_FILT]), .dout(ef.gate));

    // coil b leads coil a by a quarter period
    stmh_quarter_map u_qa (
        .phase(r.phase), .user_tab(r.ctab), .use_user(use_user),
        .mag(mag_a), .neg(neg_a));
    stmh_quarter_map u_qb (
        .phase(r.phase + 8'h40), .user_tab(r.ctab), .use_user(use_user),
        .mag(mag_b), .neg(neg_b));

    // reset image: all documented defaults
    always_comb begin
        rst_val = '0;
        rst_val.hs = stmh_pkg::HS_IDLE;
        rst_val.hc.opts = `STMH_HO_RST;
        rst_val.hc.v_app = `STMH_VAP_RST;
        rst_val.hc.v_ret = `STMH_VRE_RST;
        rst_val.hc.rpos_lo = `STMH_RPOS_RST;
        rst_val.hc.rpos_hi = `STMH_RPOS_RST;
        rst_val.fcw = `STMH_FC_RST;
        rst_val.mss = `STMH_MSS_64;
        for (int i = 0; i < NTGT; i++) begin
            rst_val.tpos[i] = `STMH_TPOS_RST;
            rst_val.tvel[i] = VW'(`STMH_TGT_RST);
            rst_val.tacc[i] = VW'(`STMH_TGT_RST);
        end
    end

    // cam seen only on enabled reference inputs
    assign cam = (r.hc.opts[`STMH_HO_REF1] & ref_in1)
        | (r.hc.opts[`STMH_HO_REF2] & ref_in2);
    // each gate bit blocks at its own level; both block always
    assign blocked = (r.fcw[`STMH_FC_GHI] & ef.gate)
        | (r.fcw[`STMH_FC_GLO] & !ef.gate);
    assign a_rise = ef.a & !r.a_q;
    assign cnt_en = r.fcw[`STMH_FC_CNT] & a_rise & ef.c & !blocked;
    // the user table only applies at the finest step size
    assign use_user = r.fcw[`STMH_FC_CTAB]
        & (r.mss == `STMH_MSS_64);
    // 64 fine steps per quarter divided by two per size code
    assign step_inc = 8'h01 << r.mss;

    // next-state logic for configuration, homing, moves, encoder and phase
    always_comb begin
        next_r = r;
        next_r.pload = 1'b0;
        next_r.mv.go = 1'b0;
        next_r.a_q = ef.a;

        // configuration load from the host side
        if (cfg_we) begin
            next_r.hc = home_cfg;
            next_r.fcw = feature_config_word;
            if (microstep_size_select <= `STMH_MSS_MAX) begin
                next_r.mss = microstep_size_select;
            end
        end

        // table writes; positions split over two halves
        if (tbl_we) begin
            unique case (tbl_sel)
                stmh_pkg::TS_TPOS_LO: next_r.tpos[tbl_idx][15:0] = tbl_wdata;
                stmh_pkg::TS_TPOS_HI: next_r.tpos[tbl_idx][31:16] = tbl_wdata;
                stmh_pkg::TS_TVEL: next_r.tvel[tbl_idx] = VW'(tbl_wdata);
                stmh_pkg::TS_TACC: next_r.tacc[tbl_idx] = VW'(tbl_wdata);
                stmh_pkg::TS_CTAB: next_r.ctab[tbl_idx] = tbl_wdata;
                default: next_r.ctab = r.ctab;
            endcase
        end

        // readback; the current table holds four 4-bit steps a word
        if (tbl_re) begin
            unique case (tbl_sel)
                stmh_pkg::TS_TPOS_LO: next_r.rdata = r.tpos[tbl_idx][15:0];
                stmh_pkg::TS_TPOS_HI: next_r.rdata = r.tpos[tbl_idx][31:16];
                stmh_pkg::TS_TVEL: next_r.rdata = 16'(r.tvel[tbl_idx]);
                stmh_pkg::TS_TACC: next_r.rdata = 16'(r.tacc[tbl_idx]);
                stmh_pkg::TS_CTAB: next_r.rdata = r.ctab[tbl_idx];
                default: next_r.rdata = 16'h0000;
            endcase
        end

        // homing sequence: seek the cam, then back off it
        unique case (r.hs)
            stmh_pkg::HS_IDLE: begin
                if (home_start && path_mode) begin
                    next_r.hs = stmh_pkg::HS_SEEK;
                    next_r.done = 1'b0;
                    next_r.hd.run = 1'b1;
                    next_r.hd.dir = r.hc.opts[`STMH_HO_REV];
                    next_r.hd.vel = r.hc.v_app;
                end
            end
            stmh_pkg::HS_SEEK: begin
                if (cam) begin
                    next_r.hs = stmh_pkg::HS_LEAVE;
                    next_r.hd.dir = !r.hc.opts[`STMH_HO_REV];
                    next_r.hd.vel = r.hc.v_ret;
                end
            end
            stmh_pkg::HS_LEAVE: begin
                if (!cam) begin
                    next_r.hs = stmh_pkg::HS_IDLE;
                    next_r.hd.run = 1'b0;
                    next_r.done = 1'b1;
                    next_r.pload = 1'b1;
                    next_r.pval = {r.hc.rpos_hi, r.hc.rpos_lo};
                end
            end
            default: next_r.hs = stmh_pkg::HS_IDLE;
        endcase

        // leaving path mode aborts homing at once
        if (!path_mode) begin
            next_r.hs = stmh_pkg::HS_IDLE;
            next_r.hd.run = 1'b0;
            next_r.pload = 1'b0;
        end

        // target move hand-off, refused while homing runs
        if (move_start && path_mode && r.hs == stmh_pkg::HS_IDLE && !home_start) begin
            next_r.mv.go = 1'b1;
            next_r.mv.tgt = r.tpos[move_idx];
            next_r.mv.vel = 16'(r.tvel[move_idx]);
            next_r.mv.acc = 16'(r.tacc[move_idx]);
        end

        // up/down count with natural wrap, no saturation
        if (cnt_en) begin
            next_r.cnt = ef.b ? r.cnt + 32'h0000_0001 : r.cnt - 32'h0000_0001;
        end

        // phase snaps to the current step grid as it advances
        if (step_pulse) begin
            next_r.phase = (step_dir ? r.phase - step_inc : r.phase + step_inc)
                & ~(step_inc - 8'h01);
        end
        next_r.ca = {neg_a, mag_a};
        next_r.cb = {neg_b, mag_b};

        // status word; show mode hides latch ack and encoder-off flag
        next_r.sw = 8'h00;
        next_r.sw[`STMH_SW_DONE] = next_r.done;
        next_r.sw[`STMH_SW_BUSY] = next_r.hd.run;
        if (r.fcw[`STMH_FC_SHOW]) begin
            next_r.sw[`STMH_SW_C] = ef.c;
            next_r.sw[`STMH_SW_G] = ef.gate;
        end else begin
            next_r.sw[`STMH_SW_C] = drive_control_word[`STMH_CW_LATCH];
            next_r.sw[`STMH_SW_G] = !r.fcw[`STMH_FC_CNT];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
            r.hc.opts <= `STMH_HO_RST;
            r.hc.v_app <= `STMH_VAP_RST;
            r.hc.v_ret <= `STMH_VRE_RST;
            r.fcw <= `STMH_FC_RST;
            for (int i = 0; i < NTGT; i++) begin
                r.tvel[i] <= VW'(`STMH_TGT_RST);
                r.tacc[i] <= VW'(`STMH_TGT_RST);
            end
        end else begin
            r <= next_r;
        end
    end

    // all outputs straight from the state register
    assign tbl_rdata = r.rdata;
    assign home_drv = r.hd;
    assign pos_load = r.pload;
    assign pos_load_val = r.pval;
    assign move = r.mv;
    assign drive_status_word = r.sw;
    assign enc_count = r.cnt;
    assign coil_a = r.ca;
    assign coil_b = r.cb;

    default clocking cb_sys @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence home_begin_s;
        r.hs == stmh_pkg::HS_IDLE && home_start && path_mode;
    endsequence
    sequence seek_hit_s;
        r.hs == stmh_pkg::HS_SEEK && cam && path_mode;
    endsequence

    home_dir_a: assert property (home_begin_s |=> home_drv.run
        && home_drv.dir == $past(r.hc.opts[`STMH_HO_REV]))
        else $error("homing seek direction wrong");
    seek_vel_a: assert property (home_begin_s |=> home_drv.vel == $past(r.hc.v_app))
        else $error("seek velocity wrong");
    ref_ignore_a: assert property (r.hs == stmh_pkg::HS_SEEK && !cam
        |=> r.hs != stmh_pkg::HS_LEAVE)
        else $error("disabled reference input ended the seek");
    leave_turn_a: assert property (seek_hit_s |=> r.hs == stmh_pkg::HS_LEAVE
        && home_drv.vel == r.hc.v_ret && home_drv.dir != r.hc.opts[`STMH_HO_REV])
        else $error("retreat leg not set up");
    ref_load_a: assert property (pos_load |-> pos_load_val
        == {r.hc.rpos_hi, r.hc.rpos_lo} && !home_drv.run)
        else $error("homing did not load reference position");
    path_only_a: assert property (!path_mode |=> !home_drv.run && !move.go)
        else $error("motion outside path mode");
    enc_count_a: assert property (cnt_en ##0 ef.b |=> enc_count == $past(enc_count) + 32'h0000_0001)
        else $error("encoder counter did not step");
    gate_block_a: assert property (blocked |=> $stable(enc_count))
        else $error("blocked gate let the counter move");
    show_sig_a: assert property (r.fcw[`STMH_FC_SHOW] |=> drive_status_word[`STMH_SW_G]
        == $past(ef.gate))
        else $error("gate level not shown in status");
    user_tab_a: assert property (r.mss != `STMH_MSS_64 |-> !use_user)
        else $error("user table used at coarse step");
    tbl_read_a: assert property (tbl_re && tbl_sel == stmh_pkg::TS_CTAB
        |=> tbl_rdata == $past(r.ctab[tbl_idx]))
        else $error("current table readback wrong");
    tgt_pick_a: assert property (move.go |-> move.acc == 16'($past(r.tacc[move_idx])))
        else $error("target acceleration not taken");
endmodule

// ==== stmh_far_side.sv ====
`timescale 1ns/1ps
// far side: cam switch on a simulated axis plus an a/b/c/gate encoder source
module stmh_far_side (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire stmh_pkg::stmh_home_drv_t home_drv,
    input wire logic [1:0] cam_wire,
    input wire logic [3:0] burst_n,
    input wire logic burst_go,
    input wire logic up,
    input wire logic c_lvl,
    input wire logic gate_lvl,
    input wire logic short_a,
    output logic ref_in1,
    output logic ref_in2,
    output stmh_pkg::stmh_enc_t enc_in,
    output logic burst_busy
);
    int pos;
    logic [3:0] left;
    logic [3:0] ph;
    logic cam;

    // cam sits at both ends of travel so either search direction finds it
    assign cam = (pos <= 0) || (pos >= 40);
    assign ref_in1 = cam & cam_wire[0];
    assign ref_in2 = cam & cam_wire[1];
    assign burst_busy = (left != 4'h0);
    // a short pulse lasts two cycles, below the input filter settle time
    assign enc_in = '{a: burst_busy && (short_a ? &ph[3:1] : ph[3]), b: up, c: c_lvl, gate: gate_lvl};

    // axis moves one unit a cycle while driven; a burst gives n periods of 16
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pos <= 20;
            left <= 4'h0;
            ph <= 4'h0;
        end else begin
            if (home_drv.run) begin
                pos <= home_drv.dir ? pos + 1 : pos - 1;
            end
            if (burst_go) begin
                left <= burst_n;
                ph <= 4'h0;
            end else if (left != 4'h0) begin
                ph <= ph + 4'h1;
                if (ph == 4'hf) begin
                    left <= left - 4'h1;
                end
            end
        end
    end
endmodule

// ==== stmh_top_tb.sv ====
`timescale 1ns/1ps
`include "stmh_defs.svh"
module stmh_top_tb;
    logic clk_sys, rst_n, path_mode, cfg_we, tbl_we, tbl_re, home_start, move_start;
    logic step_pulse, step_dir, pos_load, ref_in1, ref_in2, bgo, up, cl, gl, bbusy, shrt;
    logic [1:0] cw;
    logic [2:0] mss;
    logic [3:0] tbl_idx, move_idx, bn;
    logic [4:0] coil_a, coil_b;
    logic [7:0] sw, ph;
    logic [15:0] fcw, dcw, tbl_wdata, tbl_rdata;
    logic [31:0] pos_load_val, enc_count, rng, e;
    logic [3:0] utab [64];
    logic [15:0] efc [11] = '{16'hc000, 16'h8400, 16'he000, 16'he400, 16'hd000, 16'hf400,
                              16'hf000, 16'hc400, 16'h4000, 16'hc000, 16'h8000};
    // per encoder case, bit k: gate level, c level, short pulse, counts
    logic [10:0] egm = 11'h026, ecm = 11'h77f, esm = 11'h600, enm = 11'h40b;
    stmh_pkg::stmh_home_cfg_t hc;
    stmh_pkg::stmh_tbl_sel_t tbl_sel;
    stmh_pkg::stmh_home_drv_t hd;
    stmh_pkg::stmh_move_t mv;
    stmh_pkg::stmh_enc_t enc_in;
    int mismatches, samples_checked;

    stmh_top #(.NTGT(16), .VW(16)) dut_u (
        .clk_sys, .rst_n, .path_mode, .cfg_we, .home_cfg(hc), .feature_config_word(fcw),
        .microstep_size_select(mss), .tbl_we, .tbl_re, .tbl_sel, .tbl_idx, .tbl_wdata, .tbl_rdata,
        .home_start, .ref_in1, .ref_in2, .home_drv(hd), .pos_load, .pos_load_val, .move_start,
        .move_idx, .move(mv), .enc_in, .drive_control_word(dcw), .drive_status_word(sw),
        .enc_count, .step_pulse, .step_dir, .coil_a, .coil_b
    );
    stmh_far_side far_u (
        .clk_sys, .rst_n, .home_drv(hd), .cam_wire(cw), .burst_n(bn), .burst_go(bgo), .up,
        .c_lvl(cl), .gate_lvl(gl), .short_a(shrt), .ref_in1, .ref_in2, .enc_in, .burst_busy(bbusy)
    );

    // 100 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(logic [79:0] got, logic [79:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // a wait that ran out of cycles ends the run as a failure
    task automatic bound(int k);
        if (k >= 200) begin
            mismatches++;
            conclude();
        end
    endtask

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    // sign from the half period, magnitude mirrored in odd quarters
    function automatic logic [4:0] cur(logic [7:0] p);
        logic [5:0] i;
        i = p[6] ? 6'h3f - p[5:0] : p[5:0];
        return {p[7], utab[i]};
    endfunction

    task automatic tk(int n = 1);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic cfg(stmh_pkg::stmh_home_cfg_t h, logic [15:0] f, logic [2:0] m);
        @(posedge clk_sys);
        hc <= h;
        fcw <= f;
        mss <= m;
        cfg_we <= 1'b1;
        @(posedge clk_sys);
        cfg_we <= 1'b0;
    endtask

    // write one table word, then read it back in the next cycle
    task automatic tw(stmh_pkg::stmh_tbl_sel_t s, logic [3:0] i, logic [15:0] d);
        @(posedge clk_sys);
        tbl_we <= 1'b1;
        tbl_sel <= s;
        tbl_idx <= i;
        tbl_wdata <= d;
        @(posedge clk_sys);
        tbl_we <= 1'b0;
        tbl_re <= 1'b1;
        @(posedge clk_sys);
        tbl_re <= 1'b0;
        #1 chk(tbl_rdata, d);
    endtask

    task automatic mov(logic [3:0] i, logic [64:0] x);
        @(posedge clk_sys);
        move_start <= 1'b1;
        move_idx <= i;
        @(posedge clk_sys);
        move_start <= 1'b0;
        #1 chk(mv, x);
    endtask

    task automatic step();
        @(posedge clk_sys);
        step_pulse <= 1'b1;
        @(posedge clk_sys);
        step_pulse <= 1'b0;
        tk();
    endtask

    task automatic burst(logic [3:0] n);
        int k;
        @(posedge clk_sys);
        bn <= n;
        bgo <= 1'b1;
        @(posedge clk_sys);
        bgo <= 1'b0;
        #1 for (k = 0; k < 200 && bbusy; k++) tk();
        bound(k);
    endtask

    task automatic home(logic [1:0] w);
        int k;
        @(posedge clk_sys);
        cw <= w;
        home_start <= 1'b1;
        @(posedge clk_sys);
        home_start <= 1'b0;
        #1 chk({hd, sw[1:0]}, {1'b1, hc.opts[0], hc.v_app, 2'b10});
        for (k = 0; k < 200 && hd.dir === hc.opts[0]; k++) tk();
        bound(k);
        chk(hd, {1'b1, ~hc.opts[0], hc.v_ret});
        for (k = 0; k < 200 && pos_load !== 1'b1; k++) tk();
        bound(k);
        chk({pos_load_val, hd.run, sw[1:0]}, {hc.rpos_hi, hc.rpos_lo, 3'b001});
        // the load strobe stands for one cycle only
        tk();
        chk(pos_load, 1'b0);
    endtask

    // main sequence: defaults, homing, tables, coils, encoder, refusals
    initial begin
        logic [31:0] d, v;
        int k;
        {rst_n, cfg_we, tbl_we, tbl_re, home_start, move_start, step_pulse, step_dir, bgo, up} = '0;
        {cl, gl, shrt, cw, tbl_idx, move_idx, bn, tbl_wdata, dcw, ph, e} = '0;
        path_mode = 1'b1;
        tbl_sel = stmh_pkg::TS_TPOS_LO;
        hc = {`STMH_HO_RST, `STMH_VAP_RST, `STMH_VRE_RST, 32'h0000_0000};
        fcw = `STMH_FC_RST;
        mss = `STMH_MSS_64;
        rng = 32'd67;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        tk();
        chk(sw, 8'h80);
        mov(4'h5, {1'b1, `STMH_TPOS_RST, `STMH_TGT_RST, `STMH_TGT_RST});
        home(2'b01);
        for (k = 0; k < 3; k++) begin
            d = xs();
            v = xs();
            cfg({7'h18, d[0] | (k == 0), d[31:16], v[15:0], v[31:16], d[15:0]}, fcw, mss);
            home((d[9:8] == 2'b00) ? 2'b11 : d[9:8]);
        end
        repeat (4) begin
            d = xs();
            v = xs();
            tw(stmh_pkg::TS_TPOS_LO, v[3:0], d[15:0]);
            tw(stmh_pkg::TS_TPOS_HI, v[3:0], d[31:16]);
            tw(stmh_pkg::TS_TVEL, v[3:0], v[31:16]);
            tw(stmh_pkg::TS_TACC, v[3:0], d[23:8]);
            mov(v[3:0], {1'b1, d, v[31:16], d[23:8]});
        end
        for (k = 0; k < 64; k++) begin
            d = xs();
            utab[k] = d[3:0];
        end
        for (k = 0; k < 16; k++) begin
            tw(stmh_pkg::TS_CTAB, k[3:0], {utab[4*k+3], utab[4*k+2], utab[4*k+1], utab[4*k]});
        end
        cfg(hc, 16'h4080, `STMH_MSS_64);
        // one full electrical period at 1/64 from the user table
        for (k = 0; k < 256; k++) begin
            step();
            ph = ph + 8'h01;
            chk({coil_a, coil_b}, {cur(ph), cur(ph + 8'h40)});
        end
        for (k = 0; k < 16; k++) begin
            tw(stmh_pkg::TS_CTAB, k[3:0], 16'h0000);
        end
        cfg(hc, 16'h4080, `STMH_MSS_MAX);
        step();
        step();
        chk({coil_b[4], coil_b[3:0] != 4'h0}, 2'b11);
        cfg(hc, 16'h4080, 3'h1);
        // an undefined size code must leave the 1/32 size of code 1 in place
        cfg(hc, 16'h4080, 3'h7);
        repeat (16) step();
        chk(coil_a[3:0] != 4'h0, 1'b1);
        cfg(hc, 16'h4080, `STMH_MSS_64);
        step();
        chk(coil_a[3:0], 4'h0);
        cfg(hc, 16'h4000, `STMH_MSS_64);
        step();
        chk(coil_a[3:0] != 4'h0, 1'b1);
        // encoder cases: first counts down from zero so the counter wraps
        for (k = 0; k < 11; k++) begin
            cfg(hc, efc[k], mss);
            d = xs();
            @(posedge clk_sys);
            up <= (k == 0) ? 1'b0 : d[8];
            cl <= ecm[k];
            gl <= egm[k];
            shrt <= esm[k];
            dcw <= d[31:16];
            burst({1'b0, d[2:0]} + 4'h1);
            if (enm[k]) begin
                e = up ? e + d[2:0] + 1 : e - d[2:0] - 1;
            end
            tk(12);
            chk(enc_count, e);
            chk(sw[7:6], efc[k][10] ? {gl, cl} : {~efc[k][15], dcw[6]});
        end
        cfg({8'h10, hc[63:0]}, fcw, mss);
        @(posedge clk_sys);
        cw <= 2'b10;
        home_start <= 1'b1;
        @(posedge clk_sys);
        home_start <= 1'b0;
        tk(60);
        chk(hd, {1'b1, 1'b0, hc.v_app});
        @(posedge clk_sys);
        path_mode <= 1'b0;
        tk(2);
        chk(hd.run, 1'b0);
        @(posedge clk_sys);
        home_start <= 1'b1;
        move_start <= 1'b1;
        @(posedge clk_sys);
        home_start <= 1'b0;
        move_start <= 1'b0;
        #1 chk({hd.run, mv.go}, 2'b00);
        conclude();
    end
endmodule
